// File: src/mac_fc_defines.svh
`ifndef MAC_FC_DEFINES_SVH
`define MAC_FC_DEFINES_SVH

// Register index of the flow control register and its byte address on the port.
`define FLOW_CTRL_IDX        8'h08
`define FLOW_CTRL_ADDR       (`FLOW_CTRL_IDX * 8'h04)
`define FLOW_CTRL_RESET      32'h00000000

// Field positions inside the flow control register.
`define FLOW_PT_MSB          31
`define FLOW_PT_LSB          16
`define FLOW_PASS_BIT        2
`define FLOW_EN_BIT          1
`define FLOW_BUSY_BIT        0
`define FLOW_RSVD_WIDTH      13

// Control frame contents, FCS excluded.
`define PAUSE_DEST_ADDR      48'h0180C2000001
`define MAC_CTRL_TYPE        16'h8808
`define PAUSE_OPCODE         16'h0001
`define PAUSE_FRAME_BYTES    6'd60
`define PAUSE_LAST_IDX       6'd59
`define PAUSE_MIN_RX_BYTES   6'd18
`define RX_IDX_MAX           6'h3F

// Byte positions of the fields in a control frame.
`define IDX_SRC_ADDR         6'd6
`define IDX_TYPE_HI          6'd12
`define IDX_TYPE_LO          6'd13
`define IDX_OPC_HI           6'd14
`define IDX_OPC_LO           6'd15
`define IDX_PT_HI            6'd16
`define IDX_PT_LO            6'd17

// Pause quantum timing: one quantum is a slot of 512 bit times.
`define SLOT_BITS            512
`define CLK_PERIOD_NS        20
`define BIT_TIME_100_NS      10
`define BIT_TIME_10_NS       100
`define QUANTUM_CYC_100      ((`SLOT_BITS * `BIT_TIME_100_NS) / `CLK_PERIOD_NS)
`define QUANTUM_CYC_10       ((`SLOT_BITS * `BIT_TIME_10_NS) / `CLK_PERIOD_NS)

`endif

// File: src/mac_fc_pkg.sv
package mac_fc_pkg;

  // States of the control frame sender.
  typedef enum logic {
    TX_IDLE,
    TX_SEND
  } tx_state_type;

endpackage

// File: src/pause_tx_if.sv
`timescale 1ns/1ps

// Carries one control frame request and its byte stream between control and sender.
interface pause_tx_if;
  logic        start;
  logic [15:0] pause_time;
  logic [47:0] src_addr;
  logic        ready;
  logic [7:0]  data;
  logic        valid;
  logic        last;
  logic        busy;

  modport sender (input start, pause_time, src_addr, ready,
                  output data, valid, last, busy);
  modport ctrl   (output start, pause_time, src_addr, ready,
                  input data, valid, last, busy);
endinterface

// File: src/pause_quantum_tick.sv
`timescale 1ns/1ps
`include "mac_fc_defines.svh"

// Gives a one-cycle tick each pause quantum at the current link speed.
module pause_quantum_tick #(
  parameter int CYC_100 = `QUANTUM_CYC_100,
  parameter int CYC_10  = `QUANTUM_CYC_10
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic clear_in,
  input  wire logic run_in,
  input  wire logic speed_100_in,
  output logic      tick_out
);

  logic [11:0] cnt_r;
  logic [11:0] limit;

  // Terminal count follows the speed so a quantum is always 512 bit times.
  assign limit = speed_100_in ? 12'(CYC_100 - 1) : 12'(CYC_10 - 1);
  assign tick_out = run_in && (cnt_r >= limit);

  // Counts cycles while a pause runs and restarts on every new pause.
  always_ff @(posedge clk_in) begin
    if (srst_in || clear_in || !run_in || tick_out) begin
      cnt_r <= 12'h000;
    end else begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

endmodule

// File: src/pause_frame_sender.sv
`timescale 1ns/1ps
`include "mac_fc_defines.svh"

// Streams one control frame, byte by byte, to the transmit path.
module pause_frame_sender
  import mac_fc_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   srst_in,
  pause_tx_if.sender  tx
);

  tx_state_type state_r;
  logic [5:0]   idx_r;
  logic [15:0]  pt_r;

  // Picks the frame byte at a given position.
  function automatic logic [7:0] frame_byte(input logic [5:0] i, input logic [47:0] sa,
                                            input logic [15:0] pt);
    logic [47:0] da;
    da = `PAUSE_DEST_ADDR;
    frame_byte = 8'h00;
    if (i < `IDX_SRC_ADDR) begin
      frame_byte = da[8'(47 - 8 * i) -: 8];
    end else if (i < `IDX_TYPE_HI) begin
      frame_byte = sa[8'(47 - 8 * (i - `IDX_SRC_ADDR)) -: 8];
    end else if (i == `IDX_TYPE_HI) begin
      frame_byte = 8'(`MAC_CTRL_TYPE >> 8);
    end else if (i == `IDX_TYPE_LO) begin
      frame_byte = 8'(`MAC_CTRL_TYPE);
    end else if (i == `IDX_OPC_HI) begin
      frame_byte = 8'(`PAUSE_OPCODE >> 8);
    end else if (i == `IDX_OPC_LO) begin
      frame_byte = 8'(`PAUSE_OPCODE);
    end else if (i == `IDX_PT_HI) begin
      frame_byte = pt[15:8];
    end else if (i == `IDX_PT_LO) begin
      frame_byte = pt[7:0];
    end
  endfunction

  assign tx.busy = (state_r == TX_SEND);
  assign tx.last = tx.valid && (idx_r == `PAUSE_LAST_IDX);

  // Walks through the 60 bytes, advancing only when the transmit path takes one.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r  <= TX_IDLE;
      idx_r    <= 6'd0;
      pt_r     <= 16'h0000;
      tx.valid <= 1'b0;
      tx.data  <= 8'h00;
    end else begin
      unique case (state_r)
        TX_IDLE: begin
          if (tx.start) begin
            state_r  <= TX_SEND;
            idx_r    <= 6'd0;
            pt_r     <= tx.pause_time;
            tx.valid <= 1'b1;
            tx.data  <= frame_byte(6'd0, tx.src_addr, tx.pause_time);
          end
        end
        TX_SEND: begin
          if (tx.ready) begin
            if (idx_r == `PAUSE_LAST_IDX) begin
              state_r  <= TX_IDLE;
              tx.valid <= 1'b0;
            end else begin
              idx_r   <= idx_r + 6'd1;
              tx.data <= frame_byte(idx_r + 6'd1, tx.src_addr, pt_r);
            end
          end
        end
      endcase
    end
  end

endmodule

// File: src/mac_flow_control.sv
// What this block does
// - Transmitted pause frames carry the register's upper 16-bit pause time.
// - Pause frames follow the standard MAC control frame layout.
// - Full duplex: busy flag stays high while a control frame is being sent.
// - Half duplex: busy flag stays high while back pressure is asserted.
// - No pause frame and no back pressure while the transmitter is disabled.
// - Pass-control setting never stops frames reaching the application.
// - Pass-control set: valid received pause frames get the packet filter flag.
// - Pass-control clear: received pause frames leave the packet filter flag clear.
// - Received pause acted on only in full duplex with flow control enabled.
// - All received frame data goes to the application, bad ones too.
// - Active address filtering modes override pass-control in receive status.
// - Enabled: valid pause stops transmitter for pause time times slot time.
// - Disabled: received control frames are not acted on, no pausing.
// - Half duplex: flow control enable turns on back pressure.
// - Busy flag is bit 0, cleared when the pause frame has been sent.
`timescale 1ns/1ps
`include "mac_fc_defines.svh"

module mac_flow_control
  import mac_fc_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        SRST_IN,
  // Register port.
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic [31:0]      REG_RDATA_OUT,
  // MAC mode and requests.
  input  wire logic        FULL_DUPLEX_IN,
  input  wire logic        SPEED_100_IN,
  input  wire logic        TX_ENABLE_IN,
  input  wire logic [47:0] STATION_ADDR_IN,
  input  wire logic        PAUSE_REQ_IN,
  input  wire logic        BP_REQ_IN,
  // Control frame stream to the transmit path.
  output logic [7:0]       TXF_DATA_OUT,
  output logic             TXF_VALID_OUT,
  output logic             TXF_LAST_OUT,
  input  wire logic        TXF_READY_IN,
  output logic             BACK_PRESSURE_OUT,
  output logic             TX_PAUSE_OUT,
  // Received byte stream and filter results.
  input  wire logic [7:0]  RX_DATA_IN,
  input  wire logic        RX_VALID_IN,
  input  wire logic        RX_LAST_IN,
  input  wire logic        RX_FCS_OK_IN,
  input  wire logic        RX_ADDR_PASS_IN,
  input  wire logic        RX_FILTER_MODE_IN,
  output logic [7:0]       RX_DATA_OUT,
  output logic             RX_VALID_OUT,
  output logic             RX_LAST_OUT,
  output logic             RXS_VALID_OUT,
  output logic             RXS_PKT_FILTER_OUT,
  output logic             RXS_PAUSE_OUT
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [15:0] pause_time_value_r;
  logic        pass_ctrl_frames_r;
  logic        flow_ctrl_enable_r;
  logic        flow_busy_flag_r;
  logic        flow_busy_flag_nxt;
  logic        bp_active_r;
  logic        flow_wr;
  logic        flow_rd;
  logic [31:0] flow_word;

  logic [5:0]  rx_idx_r;
  logic        rx_match_r;
  logic        rx_match_nxt;
  logic [15:0] rx_pt_r;
  logic [7:0]  rx_expect;
  logic        rx_pause_ok;
  logic [15:0] rx_pt_full;

  logic [15:0] pause_cnt_r;
  logic        pause_load;
  logic        quantum_tick;

  pause_tx_if  ptx ();

  ////////////////////////////////////////////////////////////////////////////////
  // Register port.

  // Decodes the single mapped word; every other address reads as zero.
  assign flow_wr = REG_WR_IN && (REG_ADDR_IN == `FLOW_CTRL_ADDR);
  assign flow_rd = REG_RD_IN && (REG_ADDR_IN == `FLOW_CTRL_ADDR);

  // Assembles the readable view, reserved bits as zero.
  assign flow_word = {pause_time_value_r, {`FLOW_RSVD_WIDTH{1'b0}},
                      pass_ctrl_frames_r, flow_ctrl_enable_r, flow_busy_flag_r};

  // Stores the writable fields; the busy position is owned by hardware.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      pause_time_value_r <= 16'(`FLOW_CTRL_RESET >> `FLOW_PT_LSB);
      pass_ctrl_frames_r <= 1'b0;
      flow_ctrl_enable_r <= 1'b0;
    end else if (flow_wr) begin
      pause_time_value_r <= REG_WDATA_IN[`FLOW_PT_MSB:`FLOW_PT_LSB];
      pass_ctrl_frames_r <= REG_WDATA_IN[`FLOW_PASS_BIT];
      flow_ctrl_enable_r <= REG_WDATA_IN[`FLOW_EN_BIT];
    end
  end

  // Returns read data in the cycle after the read strobe and only there.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      REG_RDATA_OUT <= 32'h00000000;
    end else if (flow_rd) begin
      REG_RDATA_OUT <= flow_word;
    end else begin
      REG_RDATA_OUT <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control frame transmission and back pressure.

  // Hands the request, the pause time and the source address to the sender.
  assign ptx.start      = PAUSE_REQ_IN && FULL_DUPLEX_IN && TX_ENABLE_IN
                          && !ptx.busy;
  assign ptx.pause_time = pause_time_value_r;
  assign ptx.src_addr   = STATION_ADDR_IN;
  assign ptx.ready      = TXF_READY_IN;

  // Builds and streams the standard control frame.
  pause_frame_sender u_sender (
    .clk_in  (CLK_IN),
    .srst_in (SRST_IN),
    .tx      (ptx.sender)
  );

  assign TXF_DATA_OUT  = ptx.data;
  assign TXF_VALID_OUT = ptx.valid;
  assign TXF_LAST_OUT  = ptx.last;

  // Asserts back pressure only in half duplex, enabled, with the transmitter on.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      bp_active_r <= 1'b0;
    end else begin
      bp_active_r <= BP_REQ_IN && flow_ctrl_enable_r && !FULL_DUPLEX_IN
                     && TX_ENABLE_IN;
    end
  end

  assign BACK_PRESSURE_OUT = bp_active_r;

  // Busy follows the frame in full duplex and back pressure in half duplex.
  always_comb begin
    if (FULL_DUPLEX_IN) begin
      flow_busy_flag_nxt = ptx.busy && !(ptx.last && TXF_READY_IN);
    end else begin
      flow_busy_flag_nxt = bp_active_r;
    end
  end

  // Holds the busy flag seen at bit 0 of the register.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      flow_busy_flag_r <= 1'b0;
    end else begin
      flow_busy_flag_r <= flow_busy_flag_nxt || ptx.start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive path: forwarding and control frame recognition.

  // Forwards every byte unchanged, whatever the filters or errors say.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      RX_DATA_OUT  <= 8'h00;
      RX_VALID_OUT <= 1'b0;
      RX_LAST_OUT  <= 1'b0;
    end else begin
      RX_DATA_OUT  <= RX_DATA_IN;
      RX_VALID_OUT <= RX_VALID_IN;
      RX_LAST_OUT  <= RX_VALID_IN && RX_LAST_IN;
    end
  end

  // Gives the byte a control frame must hold at the current position.
  always_comb begin
    rx_expect = 8'h00;
    if (rx_idx_r < `IDX_SRC_ADDR) begin
      rx_expect = 8'(`PAUSE_DEST_ADDR >> (8 * (5 - int'(rx_idx_r))));
    end else if (rx_idx_r == `IDX_TYPE_HI) begin
      rx_expect = 8'(`MAC_CTRL_TYPE >> 8);
    end else if (rx_idx_r == `IDX_TYPE_LO) begin
      rx_expect = 8'(`MAC_CTRL_TYPE);
    end else if (rx_idx_r == `IDX_OPC_HI) begin
      rx_expect = 8'(`PAUSE_OPCODE >> 8);
    end else if (rx_idx_r == `IDX_OPC_LO) begin
      rx_expect = 8'(`PAUSE_OPCODE);
    end
  end

  // Source address and pause time positions are not compared.
  always_comb begin
    rx_match_nxt = rx_match_r;
    if (rx_idx_r < `IDX_SRC_ADDR || (rx_idx_r >= `IDX_TYPE_HI && rx_idx_r <= `IDX_OPC_LO)) begin
      rx_match_nxt = rx_match_r && (RX_DATA_IN == rx_expect);
    end
  end

  // Tracks the position in the frame, the match so far and the pause time.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      rx_idx_r   <= 6'd0;
      rx_match_r <= 1'b1;
      rx_pt_r    <= 16'h0000;
    end else if (RX_VALID_IN) begin
      if (RX_LAST_IN) begin
        rx_idx_r   <= 6'd0;
        rx_match_r <= 1'b1;
      end else begin
        rx_idx_r   <= (rx_idx_r == `RX_IDX_MAX) ? rx_idx_r : rx_idx_r + 6'd1;
        rx_match_r <= rx_match_nxt;
      end
      if (rx_idx_r == `IDX_PT_HI) begin
        rx_pt_r[15:8] <= RX_DATA_IN;
      end
      if (rx_idx_r == `IDX_PT_LO) begin
        rx_pt_r[7:0] <= RX_DATA_IN;
      end
    end
  end

  // A pause frame is valid when all fixed fields matched, it is long enough and the FCS held.
  assign rx_pause_ok = RX_VALID_IN && RX_LAST_IN && rx_match_nxt && RX_FCS_OK_IN
                       && (rx_idx_r >= `PAUSE_MIN_RX_BYTES);
  assign rx_pt_full  = rx_pt_r;

  // Produces the frame status alongside the last forwarded byte.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      RXS_VALID_OUT      <= 1'b0;
      RXS_PKT_FILTER_OUT <= 1'b0;
      RXS_PAUSE_OUT      <= 1'b0;
    end else begin
      RXS_VALID_OUT <= RX_VALID_IN && RX_LAST_IN;
      RXS_PAUSE_OUT <= rx_pause_ok;
      if (RX_FILTER_MODE_IN) begin
        RXS_PKT_FILTER_OUT <= RX_ADDR_PASS_IN;
      end else begin
        RXS_PKT_FILTER_OUT <= rx_pause_ok && pass_ctrl_frames_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pause execution.

  // Acts on a valid pause only in full duplex with flow control enabled.
  assign pause_load = rx_pause_ok && FULL_DUPLEX_IN && flow_ctrl_enable_r;

  // Ticks once per 512 bit times at the current speed.
  pause_quantum_tick u_tick (
    .clk_in       (CLK_IN),
    .srst_in      (SRST_IN),
    .clear_in     (pause_load),
    .run_in       (pause_cnt_r != 16'h0000),
    .speed_100_in (SPEED_100_IN),
    .tick_out     (quantum_tick)
  );

  // Counts the remaining quanta; a new pause replaces the old, zero resumes.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      pause_cnt_r <= 16'h0000;
    end else if (pause_load) begin
      pause_cnt_r <= rx_pt_full;
    end else if (!flow_ctrl_enable_r) begin
      pause_cnt_r <= 16'h0000;
    end else if (quantum_tick) begin
      pause_cnt_r <= pause_cnt_r - 16'h0001;
    end
  end

  assign TX_PAUSE_OUT = (pause_cnt_r != 16'h0000);

endmodule

// File: verif/mac_flow_control_props.sv
`timescale 1ns/1ps

// Watches the flow control block at its top-level ports.
module mac_flow_control_props (
  input wire logic       CLK_IN,
  input wire logic       SRST_IN,
  input wire logic       FULL_DUPLEX_IN,
  input wire logic       TX_ENABLE_IN,
  input wire logic       PAUSE_REQ_IN,
  input wire logic       BP_REQ_IN,
  input wire logic [7:0] TXF_DATA_OUT,
  input wire logic       TXF_VALID_OUT,
  input wire logic       TXF_LAST_OUT,
  input wire logic       TXF_READY_IN,
  input wire logic       BACK_PRESSURE_OUT,
  input wire logic       TX_PAUSE_OUT,
  input wire logic [7:0] RX_DATA_IN,
  input wire logic       RX_VALID_IN,
  input wire logic       RX_ADDR_PASS_IN,
  input wire logic       RX_FILTER_MODE_IN,
  input wire logic [7:0] RX_DATA_OUT,
  input wire logic       RX_VALID_OUT,
  input wire logic       RX_LAST_OUT,
  input wire logic       RXS_VALID_OUT,
  input wire logic       RXS_PKT_FILTER_OUT,
  input wire logic       RXS_PAUSE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  // A byte offered but not taken, and the final byte being taken.
  sequence s_byte_held;
    TXF_VALID_OUT && !TXF_READY_IN;
  endsequence
  sequence s_frame_done;
    TXF_VALID_OUT && TXF_LAST_OUT && TXF_READY_IN;
  endsequence

  a_frame_needs_fd: assert property ($rose(TXF_VALID_OUT) |-> TXF_DATA_OUT == 8'h01 &&
    $past(PAUSE_REQ_IN && FULL_DUPLEX_IN && TX_ENABLE_IN)) else $error("bad frame start");
  a_byte_held: assert property (s_byte_held |=> TXF_VALID_OUT && $stable(TXF_DATA_OUT))
    else $error("byte dropped");
  a_frame_end_quiet: assert property (s_frame_done |=> !TXF_VALID_OUT)
    else $error("frame runs on");
  a_bp_cause: assert property (BACK_PRESSURE_OUT |->
    $past(BP_REQ_IN && !FULL_DUPLEX_IN && TX_ENABLE_IN)) else $error("stray back pressure");
  a_rx_copied: assert property (RX_VALID_IN |=>
    RX_VALID_OUT && RX_DATA_OUT == $past(RX_DATA_IN)) else $error("rx byte lost");
  a_status_at_last: assert property (RXS_VALID_OUT |-> RX_LAST_OUT && RX_VALID_OUT)
    else $error("status off last");
  a_filter_mode_wins: assert property (RXS_VALID_OUT && $past(RX_FILTER_MODE_IN) |->
    RXS_PKT_FILTER_OUT == $past(RX_ADDR_PASS_IN)) else $error("filter flag wrong");
  a_pause_cause: assert property ($rose(TX_PAUSE_OUT) |->
    RXS_PAUSE_OUT && $past(FULL_DUPLEX_IN)) else $error("pause without cause");
endmodule

bind mac_flow_control mac_flow_control_props mac_flow_control_props_inst (.*);

// File: verif/link_partner_model.sv
`timescale 1ns/1ps

// Far-end station: takes control frame bytes and sends frames back.
module link_partner_model (
  input  wire logic       clk_in,
  input  wire logic       stall_in,
  input  wire logic [7:0] txf_data_in,
  input  wire logic       txf_valid_in,
  output logic            txf_ready_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  output logic            rx_last_out,
  output logic            rx_fcs_ok_out
);
  byte unsigned got_q[$];
  bit           sending = 1'b0;

  // Idle state of all lines toward the block.
  initial begin
    txf_ready_out = 1'b0;
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_last_out = 1'b0;
    rx_fcs_ok_out = 1'b0;
  end

  // Collects bytes, stalls at random, and keeps an idle data line moving.
  always @(posedge clk_in) begin
    if (txf_valid_in && txf_ready_out)
      got_q.push_back(txf_data_in);
    txf_ready_out <= stall_in ? ($urandom % 3 == 0) : 1'b1;
    if (!sending)
      rx_data_out <= ~rx_data_out;
  end

  // Sends one frame, one byte a cycle, with the check result on the last.
  task automatic send_frame(input byte unsigned f[$], input logic ok);
    sending = 1'b1;
    foreach (f[i]) begin
      @(posedge clk_in);
      rx_data_out <= f[i];
      rx_valid_out <= 1'b1;
      rx_last_out <= (i == f.size() - 1);
      rx_fcs_ok_out <= ok && (i == f.size() - 1);
    end
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_last_out <= 1'b0;
    rx_fcs_ok_out <= 1'b0;
    sending = 1'b0;
  endtask
endmodule

// File: verif/mac_flow_control_test.sv
`timescale 1ns/1ps
`include "mac_fc_defines.svh"

// Drives the flow control block and compares it with a model of its rules.
module mac_flow_control_test;
  typedef byte unsigned bq_type[$];
  logic        CLK_IN, SRST_IN, REG_WR_IN, REG_RD_IN, FULL_DUPLEX_IN, SPEED_100_IN;
  logic        TX_ENABLE_IN, PAUSE_REQ_IN, BP_REQ_IN, TXF_VALID_OUT, TXF_LAST_OUT;
  logic        TXF_READY_IN, BACK_PRESSURE_OUT, TX_PAUSE_OUT, RX_VALID_IN, RX_LAST_IN;
  logic        RX_FCS_OK_IN, RX_ADDR_PASS_IN, RX_FILTER_MODE_IN, RX_VALID_OUT, RX_LAST_OUT;
  logic        RXS_VALID_OUT, RXS_PKT_FILTER_OUT, RXS_PAUSE_OUT, stall, st_filt, st_pause;
  logic [7:0]  REG_ADDR_IN, TXF_DATA_OUT, RX_DATA_IN, RX_DATA_OUT;
  logic [31:0] REG_WDATA_IN, REG_RDATA_OUT, d;
  logic [47:0] STATION_ADDR_IN;
  logic [15:0] pt;
  logic [5:0]  c;
  int          n_mismatch, comparisons, st_n, rx_n, p_cyc;
  bq_type      exp_q;
  logic [5:0]  cases [6] = '{6'b111001, 6'b011011, 6'b101001, 6'b110001, 6'b111101, 6'b111000};

  mac_flow_control mac_flow_control_inst (.*);
  link_partner_model link_partner_model_inst (.clk_in(CLK_IN), .stall_in(stall),
    .txf_data_in(TXF_DATA_OUT), .txf_valid_in(TXF_VALID_OUT), .txf_ready_out(TXF_READY_IN),
    .rx_data_out(RX_DATA_IN), .rx_valid_out(RX_VALID_IN), .rx_last_out(RX_LAST_IN),
    .rx_fcs_ok_out(RX_FCS_OK_IN));

  // Clock of 20 ns.
  always #10 CLK_IN = ~CLK_IN;

  // Counts status pulses, forwarded bytes and paused cycles.
  always @(posedge CLK_IN) begin
    if (RXS_VALID_OUT) begin
      st_n++;
      st_filt = RXS_PKT_FILTER_OUT;
      st_pause = RXS_PAUSE_OUT;
    end
    if (RX_VALID_OUT)
      rx_n++;
    if (TX_PAUSE_OUT)
      p_cyc++;
  end

  // Expected control frame bytes for a source address and pause time.
  function automatic bq_type frame(input logic [47:0] sa, input logic [15:0] t);
    logic [47:0] da;
    bq_type      q;
    da = `PAUSE_DEST_ADDR;
    for (int i = 5; i >= 0; i--) q.push_back(da[i*8 +: 8]);
    for (int i = 5; i >= 0; i--) q.push_back(sa[i*8 +: 8]);
    q = {q, 8'h88, 8'h08, 8'h00, 8'h01, t[15:8], t[7:0]};
    while (q.size() < 60) q.push_back(8'h00);
    return q;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_IN);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK_IN);
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= v;
    REG_WR_IN <= 1'b1;
    @(posedge CLK_IN);
    REG_WR_IN <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLK_IN);
    REG_ADDR_IN <= a;
    REG_RD_IN <= 1'b1;
    @(posedge CLK_IN);
    REG_RD_IN <= 1'b0;
    @(negedge CLK_IN);
    v = REG_RDATA_OUT;
  endtask

  task automatic pulse_req();
    @(posedge CLK_IN);
    PAUSE_REQ_IN <= 1'b1;
    @(posedge CLK_IN);
    PAUSE_REQ_IN <= 1'b0;
  endtask

  task automatic final_report();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    tick(20000);
    n_mismatch++;
    final_report();
  end

  // Main sequence of tests.
  initial begin
    {CLK_IN, REG_WR_IN, REG_RD_IN, PAUSE_REQ_IN, BP_REQ_IN, stall} = '0;
    {RX_ADDR_PASS_IN, RX_FILTER_MODE_IN, REG_ADDR_IN, REG_WDATA_IN} = '0;
    {FULL_DUPLEX_IN, TX_ENABLE_IN, SPEED_100_IN, SRST_IN} = 4'hF;
    void'($urandom(32'h0523));
    pt = 16'($urandom);
    STATION_ADDR_IN = {16'($urandom), 32'($urandom)};
    tick(5);
    SRST_IN <= 1'b0;
    reg_rd(`FLOW_CTRL_ADDR, d);
    check(d, `FLOW_CTRL_RESET, "reset value");
    reg_wr(8'h24, 32'hFFFFFFFF);
    reg_rd(8'h24, d);
    check(d, 32'h0, "unmapped read");
    reg_wr(`FLOW_CTRL_ADDR, {pt, 16'h0004});
    reg_wr(`FLOW_CTRL_ADDR, {pt, 16'h0006});
    reg_rd(`FLOW_CTRL_ADDR, d);
    check(d, {pt, 16'h0006}, "register fields");
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      FULL_DUPLEX_IN <= m[0];
      TX_ENABLE_IN <= !m[0];
      pulse_req();
      tick(4);
      check(TXF_VALID_OUT, 0, "frame while barred");
    end
    TX_ENABLE_IN <= 1'b1;
    stall <= 1'b1;
    pulse_req();
    reg_rd(`FLOW_CTRL_ADDR, d);
    check(d[0], 1, "busy while sending");
    for (int i = 0; i < 400 && link_partner_model_inst.got_q.size() < 60; i++) tick(1);
    tick(2);
    exp_q = frame(STATION_ADDR_IN, pt);
    check(link_partner_model_inst.got_q.size(), 60, "frame length");
    foreach (exp_q[i]) check(link_partner_model_inst.got_q[i], exp_q[i], "frame byte");
    check(TXF_VALID_OUT, 0, "frame ended");
    reg_rd(`FLOW_CTRL_ADDR, d);
    check(d, {pt, 16'h0006}, "busy cleared");
    $display("test pause frame done");
    FULL_DUPLEX_IN <= 1'b0;
    BP_REQ_IN <= 1'b1;
    tick(3);
    check(BACK_PRESSURE_OUT, 1, "back pressure on");
    reg_rd(`FLOW_CTRL_ADDR, d);
    check(d[0], 1, "busy in back pressure");
    TX_ENABLE_IN <= 1'b0;
    tick(3);
    check(BACK_PRESSURE_OUT, 0, "back pressure with tx off");
    BP_REQ_IN <= 1'b0;
    TX_ENABLE_IN <= 1'b1;
    tick(3);
    $display("test back pressure done");
    foreach (cases[k]) begin
      c = cases[k];
      reg_wr(`FLOW_CTRL_ADDR, {16'h0002, 13'h0, c[5], c[4], 1'b0});
      FULL_DUPLEX_IN <= c[3];
      RX_FILTER_MODE_IN <= c[2];
      RX_ADDR_PASS_IN <= c[1];
      st_n = 0;
      rx_n = 0;
      p_cyc = 0;
      link_partner_model_inst.send_frame(frame(~STATION_ADDR_IN, 16'h0002), c[0]);
      tick(2);
      for (int i = 0; i < 800 && TX_PAUSE_OUT; i++) tick(1);
      tick(1);
      check(st_n, 1, "status count");
      check(rx_n, 60, "bytes forwarded");
      check(st_filt, c[2] ? c[1] : c[0] & c[5], "filter flag");
      check(st_pause, c[0], "pause detected");
      check((p_cyc + 128) / 256, (c[0] & c[4] & c[3]) ? 2 : 0, "pause quanta");
      $display("test receive case %0d done", k);
    end
    SPEED_100_IN <= 1'b0;
    reg_wr(`FLOW_CTRL_ADDR, {16'h0001, 16'h0006});
    p_cyc = 0;
    link_partner_model_inst.send_frame(frame(~STATION_ADDR_IN, 16'h0001), 1'b1);
    tick(2);
    for (int i = 0; i < 3000 && TX_PAUSE_OUT; i++) tick(1);
    check((p_cyc + 1280) / 2560, 1, "slow quantum");
    $display("test slow link pause done");
    final_report();
  end
endmodule
